// ---- rtl/wdog_regs.svh ----
`ifndef WDOG_REGS_SVH
`define WDOG_REGS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define WD_IDX_CTRL 16'hF020
`define WD_IDX_PRE_COUNT 16'hF021
`define WD_IDX_PRE_WRAP 16'hF022
`define WD_IDX_COUNTDOWN 16'hF023
`define WD_IDX_FIRED 16'hF024
`define WD_IDX_IRQ_STATUS 16'hF025
`define WD_IDX_IRQ_MASK 16'hF026

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define WD_CTRL_RUN_BIT 0
`define WD_CTRL_TRIG_BIT 1
`define WD_FIRED_BIT 0
`define WD_IRQ_EXPIRE_BIT 0
`define WD_IRQ_RESET_BIT 1

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define WD_CTRL_RST 2'h0
`define WD_PRE_COUNT_RST 16'h0000
`define WD_PRE_WRAP_RST 16'hFFFF
`define WD_COUNTDOWN_RST 12'hFFF
`define WD_IRQ_RST 2'h0

// ----------------------------------------------------------------
// timing counts and bus answers
// ----------------------------------------------------------------
`define WD_CHIP_RST_CYCLES 8'h10
`define WD_RESP_OKAY 2'h0
`define WD_RESP_SLVERR 2'h2

`endif

// ---- rtl/wdog_pkg.sv ----
package wdog_pkg;

  // ----------------------------------------------------------------
  // register select after address decode
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SEL_CTRL = 3'h0,
    SEL_PRE_COUNT = 3'h1,
    SEL_PRE_WRAP = 3'h2,
    SEL_COUNTDOWN = 3'h3,
    SEL_FIRED = 3'h4,
    SEL_IRQ_STATUS = 3'h5,
    SEL_IRQ_MASK = 3'h6,
    SEL_NONE = 3'h7
  } reg_sel_t;

  // ----------------------------------------------------------------
  // chip reset driver states
  // ----------------------------------------------------------------
  typedef enum logic {
    RST_IDLE = 1'b0,
    RST_DRIVE = 1'b1
  } rst_state_t;

endpackage : wdog_pkg

// ---- rtl/wdog_prescaler.sv ----
`timescale 1ns/1ps
`include "wdog_regs.svh"

module wdog_prescaler #(
  parameter int WIDTH = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic crystal_input_pin,
  input wire logic [WIDTH-1:0] wrap_value,
  output logic [WIDTH-1:0] count,
  output logic tick
);

  // ----------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------
  if (WIDTH != 16) begin : g_width_check
    $error("wdog_prescaler: WIDTH must be 16");
  end

  logic xtal_prev_ff;
  logic [WIDTH-1:0] count_ff;
  logic tick_ff;
  logic nxt_xtal_prev;
  logic [WIDTH-1:0] nxt_count;
  logic nxt_tick;

  // count rising crystal edges, wrap to zero at the programmed value
  always_comb begin
    nxt_xtal_prev = crystal_input_pin;
    nxt_count = count_ff;
    nxt_tick = 1'b0;
    if (crystal_input_pin && !xtal_prev_ff) begin
      if (count_ff == wrap_value) begin
        nxt_count = '0;
        nxt_tick = 1'b1;
      end else begin
        nxt_count = count_ff + 1'b1;
      end
    end
  end

  // registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      xtal_prev_ff <= 1'b0;
      count_ff <= `WD_PRE_COUNT_RST;
      tick_ff <= 1'b0;
    end else begin
      xtal_prev_ff <= nxt_xtal_prev;
      count_ff <= nxt_count;
      tick_ff <= nxt_tick;
    end
  end

  assign count = count_ff;
  assign tick = tick_ff;

endmodule : wdog_prescaler

// ---- rtl/wdog_top.sv ----
`timescale 1ns/1ps
`include "wdog_regs.svh"


module wdog_top #(
  parameter int ADDR_W = 18,
  parameter int COUNT_W = 12,
  parameter int PRE_W = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic crystal_input_pin,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic chip_reset,
  output logic irq
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  if (ADDR_W < 18 || ADDR_W > 32) begin : g_addr_check
    $error("wdog_top: ADDR_W must be 18..32");
  end
  if (COUNT_W != 12 || PRE_W != 16) begin : g_width_check
    $error("wdog_top: COUNT_W must be 12 and PRE_W 16");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // word index to register select
  function automatic wdog_pkg::reg_sel_t decode(input logic [ADDR_W-1:0] addr);
    logic [15:0] idx;
    idx = addr[17:2];
    if ((addr >> 18) != '0) begin
      decode = wdog_pkg::SEL_NONE;
    end else begin
      case (idx)
        `WD_IDX_CTRL: decode = wdog_pkg::SEL_CTRL;
        `WD_IDX_PRE_COUNT: decode = wdog_pkg::SEL_PRE_COUNT;
        `WD_IDX_PRE_WRAP: decode = wdog_pkg::SEL_PRE_WRAP;
        `WD_IDX_COUNTDOWN: decode = wdog_pkg::SEL_COUNTDOWN;
        `WD_IDX_FIRED: decode = wdog_pkg::SEL_FIRED;
        `WD_IDX_IRQ_STATUS: decode = wdog_pkg::SEL_IRQ_STATUS;
        `WD_IDX_IRQ_MASK: decode = wdog_pkg::SEL_IRQ_MASK;
        default: decode = wdog_pkg::SEL_NONE;
      endcase
    end
  endfunction : decode

  // byte-lane merge of write data into an old value
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    merge = res;
  endfunction : merge

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic aw_got_ff, nxt_aw_got;
  logic [ADDR_W-1:0] aw_addr_ff, nxt_aw_addr;
  logic w_got_ff, nxt_w_got;
  logic [31:0] w_data_ff, nxt_w_data;
  logic [3:0] w_strb_ff, nxt_w_strb;
  logic awready_ff, nxt_awready;
  logic wready_ff, nxt_wready;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic arready_ff, nxt_arready;
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;
  logic do_wr;
  wdog_pkg::reg_sel_t wr_sel;

  logic [1:0] ctrl_ff, nxt_ctrl;
  logic [PRE_W-1:0] wrap_ff, nxt_wrap;
  logic [COUNT_W-1:0] countdown_ff, nxt_countdown;
  logic fired_ff, nxt_fired;
  logic [1:0] irq_status_ff, nxt_irq_status;
  logic [1:0] irq_mask_ff, nxt_irq_mask;
  logic irq_ff, nxt_irq;
  wdog_pkg::rst_state_t rst_state_ff, nxt_rst_state;
  logic [7:0] rst_cnt_ff, nxt_rst_cnt;
  logic chip_reset_ff, nxt_chip_reset;
  logic expire;
  logic [31:0] wr_merged;

  logic [PRE_W-1:0] pre_count;
  logic pre_tick;

  // ----------------------------------------------------------------
  // prescaler
  // ----------------------------------------------------------------
  wdog_prescaler #(
    .WIDTH(PRE_W)
  ) i_wdog_prescaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .crystal_input_pin(crystal_input_pin),
    .wrap_value(wrap_ff),
    .count(pre_count),
    .tick(pre_tick)
  );

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  // address and data taken in either order, response after both
  always_comb begin
    nxt_aw_got = aw_got_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_got = w_got_ff;
    nxt_w_data = w_data_ff;
    nxt_w_strb = w_strb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_arready = arready_ff;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    do_wr = aw_got_ff && w_got_ff && !bvalid_ff;
    wr_sel = decode(aw_addr_ff);
    if (awvalid && awready_ff) begin
      nxt_aw_got = 1'b1;
      nxt_aw_addr = awaddr;
    end
    if (wvalid && wready_ff) begin
      nxt_w_got = 1'b1;
      nxt_w_data = wdata;
      nxt_w_strb = wstrb;
    end
    if (do_wr) begin
      nxt_aw_got = 1'b0;
      nxt_w_got = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = (wr_sel == wdog_pkg::SEL_NONE) ? `WD_RESP_SLVERR : `WD_RESP_OKAY;
    end else if (bvalid_ff && bready) begin
      nxt_bvalid = 1'b0;
    end
    nxt_awready = !nxt_aw_got && !nxt_bvalid;
    nxt_wready = !nxt_w_got && !nxt_bvalid;
    // read path, reserved bits zero
    if (arvalid && arready_ff) begin
      nxt_arready = 1'b0;
      nxt_rvalid = 1'b1;
      nxt_rresp = `WD_RESP_OKAY;
      nxt_rdata = 32'h00000000;
      case (decode(araddr))
        wdog_pkg::SEL_CTRL: nxt_rdata[1:0] = ctrl_ff;
        wdog_pkg::SEL_PRE_COUNT: nxt_rdata[15:0] = pre_count;
        wdog_pkg::SEL_PRE_WRAP: nxt_rdata[15:0] = wrap_ff;
        wdog_pkg::SEL_COUNTDOWN: nxt_rdata[11:0] = countdown_ff;
        wdog_pkg::SEL_FIRED: nxt_rdata[`WD_FIRED_BIT] = fired_ff;
        wdog_pkg::SEL_IRQ_STATUS: nxt_rdata[1:0] = irq_status_ff;
        wdog_pkg::SEL_IRQ_MASK: nxt_rdata[1:0] = irq_mask_ff;
        default: nxt_rresp = `WD_RESP_SLVERR;
      endcase
    end else if (rvalid_ff && rready) begin
      nxt_rvalid = 1'b0;
      nxt_arready = 1'b1;
    end
  end

  // bus registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_got_ff <= 1'b0;
      w_data_ff <= 32'h00000000;
      w_strb_ff <= 4'h0;
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= `WD_RESP_OKAY;
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= `WD_RESP_OKAY;
    end else begin
      aw_got_ff <= nxt_aw_got;
      aw_addr_ff <= nxt_aw_addr;
      w_got_ff <= nxt_w_got;
      w_data_ff <= nxt_w_data;
      w_strb_ff <= nxt_w_strb;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  // ----------------------------------------------------------------
  // watchdog core
  // ----------------------------------------------------------------
  // register writes, countdown stepping, expiry and chip reset
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_wrap = wrap_ff;
    nxt_countdown = countdown_ff;
    nxt_fired = fired_ff;
    nxt_irq_status = irq_status_ff;
    nxt_irq_mask = irq_mask_ff;
    nxt_rst_state = rst_state_ff;
    nxt_rst_cnt = rst_cnt_ff;
    nxt_chip_reset = 1'b0;
    expire = 1'b0;
    wr_merged = 32'h00000000;
    // step once per prescaler period while running
    if (pre_tick && ctrl_ff[`WD_CTRL_RUN_BIT]) begin
      expire = (countdown_ff <= 12'h001);
      nxt_countdown = (countdown_ff == 12'h000) ? 12'h000 : countdown_ff - 12'h001;
    end
    if (do_wr) begin
      case (wr_sel)
        wdog_pkg::SEL_CTRL: begin
          wr_merged = merge({30'h0, ctrl_ff}, w_data_ff, w_strb_ff);
          nxt_ctrl = wr_merged[1:0];
        end
        wdog_pkg::SEL_PRE_WRAP: begin
          wr_merged = merge({16'h0000, wrap_ff}, w_data_ff, w_strb_ff);
          nxt_wrap = wr_merged[15:0];
        end
        wdog_pkg::SEL_COUNTDOWN: begin
          wr_merged = merge({20'h00000, countdown_ff}, w_data_ff, w_strb_ff);
          nxt_countdown = wr_merged[11:0];
          expire = 1'b0;
        end
        wdog_pkg::SEL_IRQ_STATUS: begin
          nxt_irq_status = irq_status_ff & ~(w_data_ff[1:0] & {2{w_strb_ff[0]}});
        end
        wdog_pkg::SEL_IRQ_MASK: begin
          wr_merged = merge({30'h0, irq_mask_ff}, w_data_ff, w_strb_ff);
          nxt_irq_mask = wr_merged[1:0];
        end
        default: wr_merged = 32'h00000000;
      endcase
    end
    // event sets win over a clear in the same cycle
    if (expire) begin
      nxt_irq_status[`WD_IRQ_EXPIRE_BIT] = 1'b1;
    end
    case (rst_state_ff)
      wdog_pkg::RST_IDLE: begin
        if (expire && ctrl_ff[`WD_CTRL_TRIG_BIT]) begin
          nxt_rst_state = wdog_pkg::RST_DRIVE;
          nxt_rst_cnt = `WD_CHIP_RST_CYCLES - 8'h01;
          nxt_chip_reset = 1'b1;
          nxt_fired = 1'b1;
          nxt_irq_status[`WD_IRQ_RESET_BIT] = 1'b1;
        end
      end
      wdog_pkg::RST_DRIVE: begin
        if (rst_cnt_ff == 8'h00) begin
          nxt_rst_state = wdog_pkg::RST_IDLE;
        end else begin
          nxt_rst_cnt = rst_cnt_ff - 8'h01;
          nxt_chip_reset = 1'b1;
        end
      end
      default: nxt_rst_state = wdog_pkg::RST_IDLE;
    endcase
    nxt_irq = |(nxt_irq_status & nxt_irq_mask);
  end

  // core registers; only power-on reset clears the fired flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_ff <= `WD_CTRL_RST;
      wrap_ff <= `WD_PRE_WRAP_RST;
      countdown_ff <= `WD_COUNTDOWN_RST;
      fired_ff <= 1'b0;
      irq_status_ff <= `WD_IRQ_RST;
      irq_mask_ff <= `WD_IRQ_RST;
      irq_ff <= 1'b0;
      rst_state_ff <= wdog_pkg::RST_IDLE;
      rst_cnt_ff <= 8'h00;
      chip_reset_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      wrap_ff <= nxt_wrap;
      countdown_ff <= nxt_countdown;
      fired_ff <= nxt_fired;
      irq_status_ff <= nxt_irq_status;
      irq_mask_ff <= nxt_irq_mask;
      irq_ff <= nxt_irq;
      rst_state_ff <= nxt_rst_state;
      rst_cnt_ff <= nxt_rst_cnt;
      chip_reset_ff <= nxt_chip_reset;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign awready = awready_ff;
  assign wready = wready_ff;
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;
  assign arready = arready_ff;
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;
  assign chip_reset = chip_reset_ff;
  assign irq = irq_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  reset_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |-> (ctrl_ff == 2'h0 && !chip_reset_ff))
    else $error("control not cleared after reset");

  trig_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(chip_reset_ff) |-> $past(ctrl_ff[`WD_CTRL_TRIG_BIT]))
    else $error("chip reset without trigger enable");

  count_only_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (expire && !ctrl_ff[`WD_CTRL_TRIG_BIT] && rst_state_ff == wdog_pkg::RST_IDLE)
      |=> !chip_reset_ff)
    else $error("count-only mode reset the chip");

  run_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!ctrl_ff[`WD_CTRL_RUN_BIT] && !do_wr) |=> $stable(countdown_ff))
    else $error("countdown moved while stopped");

  pre_wrap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pre_tick |-> (pre_count == 16'h0000))
    else $error("prescaler not zero at wrap");

  step_down_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (pre_tick && ctrl_ff[`WD_CTRL_RUN_BIT] && !do_wr && countdown_ff != 12'h000)
      |=> (countdown_ff == $past(countdown_ff) - 12'h001))
    else $error("countdown did not step by one");

  expire_reset_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (pre_tick && ctrl_ff == 2'h3 && countdown_ff == 12'h001 && !do_wr
      && rst_state_ff == wdog_pkg::RST_IDLE)
      |=> chip_reset_ff [*8])
    else $error("expiry did not drive chip reset");

  fired_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
    fired_ff |=> fired_ff)
    else $error("fired flag dropped without power-on reset");

  load_count_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (do_wr && wr_sel == wdog_pkg::SEL_COUNTDOWN && w_strb_ff == 4'hF)
      |=> (countdown_ff == $past(w_data_ff[11:0])))
    else $error("countdown write not loaded");

  reserved_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid_ff |-> (rdata_ff[31:16] == 16'h0000))
    else $error("reserved bits read nonzero");

endmodule : wdog_top

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
`include "wdog_regs.svh"

module tb_top;

  // ----------------------------------------------------------------
  // compare helper
  // ----------------------------------------------------------------
  `define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin miscompares++; \
    $display("Error t=%0t got %h exp %h", $time, (a), (e)); end end

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic aclk;
  logic aresetn;
  logic crystal_input_pin;
  logic [17:0] awaddr;
  logic awvalid;
  logic awready;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic wvalid;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [17:0] araddr;
  logic arvalid;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready;
  logic chip_reset;
  logic irq;
  int miscompares = 0;
  int n_tests = 0;
  int rst_cycles = 0;
  logic [31:0] rd_d;
  logic [1:0] rd_r;

  wdog_top i_wdog_top (
    .aclk(aclk), .aresetn(aresetn), .crystal_input_pin(crystal_input_pin),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .chip_reset(chip_reset), .irq(irq)
  );

  // 100 ns clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // counts cycles with the chip reset pulse high
  always @(posedge aclk) begin
    if (chip_reset === 1'b1) rst_cycles++;
  end

  // ----------------------------------------------------------------
  // bus and stimulus tasks
  // ----------------------------------------------------------------
  // waits for the answer however long it takes; only the run watchdog ends a hang
  task automatic wr(input logic [15:0] idx, input logic [31:0] d, input logic [1:0] er,
                    input logic [3:0] s = 4'hF);
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    `CHK(bresp, er)
  endtask : wr

  task automatic rd(input logic [15:0] idx);
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd_d = rdata;
    rd_r = rresp;
    rready <= 1'b0;
  endtask : rd

  // read and compare data, expecting an okay answer
  task automatic rchk(input logic [15:0] idx, input logic [31:0] e);
    rd(idx);
    `CHK(rd_r, 2'h0)
    `CHK(rd_d, e)
  endtask : rchk

  // n rising edges on the crystal input, then settle
  task automatic xtal(input int n);
    repeat (n) begin
      @(posedge aclk);
      crystal_input_pin <= 1'b1;
      @(posedge aclk);
      crystal_input_pin <= 1'b0;
    end
    repeat (4) @(posedge aclk);
  endtask : xtal

  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : results

  // ----------------------------------------------------------------
  // watchdog on the run itself
  // ----------------------------------------------------------------
  initial begin
    #(100 * 5000);
    miscompares++;
    results();
  end

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    aresetn = 1'b0;
    crystal_input_pin = 1'b0;
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    // reset values
    rchk(`WD_IDX_CTRL, 32'h0);
    rchk(`WD_IDX_PRE_COUNT, 32'h0);
    rchk(`WD_IDX_PRE_WRAP, 32'h0000FFFF);
    rchk(`WD_IDX_COUNTDOWN, 32'h00000FFF);
    rchk(`WD_IDX_FIRED, 32'h0);
    rchk(`WD_IDX_IRQ_STATUS, 32'h0);
    rchk(`WD_IDX_IRQ_MASK, 32'h0);
    `CHK(irq, 1'b0)
    `CHK(chip_reset, 1'b0)
    $display("test reset values done");
    // reserved bits, read-only places, unmapped index
    wr(`WD_IDX_CTRL, 32'hFFFFFFFC, 2'h0);
    rchk(`WD_IDX_CTRL, 32'h0);
    wr(`WD_IDX_PRE_WRAP, 32'hFFFF0003, 2'h0);
    rchk(`WD_IDX_PRE_WRAP, 32'h00000003);
    wr(`WD_IDX_COUNTDOWN, 32'hFFFFF00A, 2'h0);
    rchk(`WD_IDX_COUNTDOWN, 32'h0000000A);
    wr(`WD_IDX_PRE_COUNT, 32'h00001234, 2'h0);
    rchk(`WD_IDX_PRE_COUNT, 32'h0);
    wr(`WD_IDX_FIRED, 32'h00000001, 2'h0);
    rchk(`WD_IDX_FIRED, 32'h0);
    wr(16'hF027, 32'h1, 2'h2);
    rd(16'hF027);
    `CHK(rd_r, 2'h2)
    `CHK(rd_d, 32'h0)
    $display("test reserved and unmapped done");
    // prescaler with wrap 3, countdown held while not running
    xtal(6);
    rchk(`WD_IDX_PRE_COUNT, 32'h2);
    xtal(2);
    rchk(`WD_IDX_PRE_COUNT, 32'h0);
    rchk(`WD_IDX_COUNTDOWN, 32'h0000000A);
    $display("test prescaler done");
    // count-only mode with interrupt
    wr(`WD_IDX_IRQ_MASK, 32'h1, 2'h0);
    wr(`WD_IDX_CTRL, 32'h1, 2'h0);
    xtal(4);
    rchk(`WD_IDX_COUNTDOWN, 32'h9);
    wr(`WD_IDX_COUNTDOWN, 32'h1, 2'h0);
    rchk(`WD_IDX_COUNTDOWN, 32'h1);
    xtal(4);
    wr(`WD_IDX_CTRL, 32'h0, 2'h0);
    rchk(`WD_IDX_COUNTDOWN, 32'h0);
    `CHK(rst_cycles, 0)
    rchk(`WD_IDX_FIRED, 32'h0);
    rchk(`WD_IDX_IRQ_STATUS, 32'h1);
    `CHK(irq, 1'b1)
    wr(`WD_IDX_IRQ_MASK, 32'h0, 2'h0);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b0)
    wr(`WD_IDX_IRQ_STATUS, 32'h3, 2'h0);
    rchk(`WD_IDX_IRQ_STATUS, 32'h0);
    $display("test count only done");
    // triggering mode: rewrite keeps it alive, then expiry
    wr(`WD_IDX_COUNTDOWN, 32'h2, 2'h0);
    wr(`WD_IDX_CTRL, 32'h3, 2'h0);
    xtal(4);
    wr(`WD_IDX_COUNTDOWN, 32'h2, 2'h0);
    xtal(4);
    rchk(`WD_IDX_COUNTDOWN, 32'h1);
    `CHK(rst_cycles, 0)
    xtal(4);
    wr(`WD_IDX_CTRL, 32'h0, 2'h0);
    repeat (20) @(posedge aclk);
    `CHK(rst_cycles, `WD_CHIP_RST_CYCLES)
    `CHK(chip_reset, 1'b0)
    rchk(`WD_IDX_FIRED, 32'h1);
    rd(`WD_IDX_IRQ_STATUS);
    `CHK(rd_d[1], 1'b1)
    $display("test trigger done");
    // power-on reset clears the fired flag
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(`WD_IDX_FIRED, 32'h0);
    rchk(`WD_IDX_CTRL, 32'h0);
    rchk(`WD_IDX_COUNTDOWN, 32'h00000FFF);
    // byte lane zero only replaces the low byte of the wrap value
    wr(`WD_IDX_PRE_WRAP, 32'h12345678, 2'h0, 4'h1);
    rchk(`WD_IDX_PRE_WRAP, 32'h0000FF78);
    $display("test power-on reset done");
    results();
  end

endmodule : tb_top
